// file: exrv_exc_select.sv
// Priority selection of non-reset exception sources
`timescale 1ns/1ps
module exrv_exc_select
    import exrv_pkg::*;
(
    input wire logic ae_cpu, // CPU address error
    input wire logic ae_xfer, // Transfer-unit address error
    input wire logic nmi, // Non-maskable interrupt
    input wire logic ubrk, // User break request
    input wire logic irq_req, // Maskable request from interrupt controller
    input wire logic [3:0] irq_level, // Its priority level
    input wire logic [7:0] irq_vec, // Its vector, 64 to 255
    input wire logic trap_req, // Trap instruction executing
    input wire logic [4:0] trap_num, // Trap number, maps to 32..63
    input wire logic ill_gen, // General illegal instruction
    input wire logic ill_slot, // Slot illegal instruction
    input wire logic [3:0] mask, // Current interrupt mask field
    output exrv_exc_t sel // Winning exception
);
    always_comb begin
        sel = '0;
        if (ae_cpu) begin
            sel = '{1'b1, VEC_AE_CPU, 1'b0, mask}; // [RULE11]
        end else if (ae_xfer) begin
            sel = '{1'b1, VEC_AE_XFER, 1'b0, mask}; // [RULE11]
        end else if (nmi) begin
            sel = '{1'b1, VEC_NMI, 1'b1, MASK_NMI}; // [RULE12] [RULE22] [RULE23]
        end else if (ubrk && LEVEL_UBRK > mask) begin
            sel = '{1'b1, VEC_UBRK, 1'b1, LEVEL_UBRK}; // [RULE12] [RULE23]
        end else if (irq_req && irq_level > mask) begin
            sel = '{1'b1, irq_vec, 1'b1, irq_level}; // [RULE12] [RULE23]
        end else if (trap_req) begin
            sel = '{1'b1, VEC_TRAP_LO + {3'h0, trap_num}, 1'b0, mask}; // [RULE12]
        end else if (ill_slot) begin
            sel = '{1'b1, VEC_ILL_SLOT, 1'b0, mask}; // [RULE11]
        end else if (ill_gen) begin
            sel = '{1'b1, VEC_ILL_GEN, 1'b0, mask}; // [RULE11]
        end
    end

endmodule : exrv_exc_select

// file: exrv_exc_seq.sv
// Exception entry sequencer: resets, vector fetch, stacking and mask update
// Notes on behaviour
// [RULE1] Power-on reset: PC from 0, SP from 4
// [RULE2] Manual reset: PC from 8, SP from 0xC
// [RULE3] Reset clears vector base, mask to ones
// [RULE4] Fetched PC and SP loaded, execution starts
// [RULE5] Other exceptions stack status word and PC
// [RULE6] Interrupt entry writes accepted level to mask
// [RULE7] Error and instruction entries keep mask
// [RULE8] Then fetch handler address and jump
// [RULE9] Reset table address is vector times four
// [RULE10] Other table addresses add vector base
// [RULE11] Vectors 4,6,9,10 used; 5,7,8 reserved
// [RULE12] NMI 11, break 12, traps 32-63, requests 64+
// [RULE13] Resets beat every other exception
// [RULE14] Power-on reset also resets peripherals
// [RULE15] Manual reset spares peripheral registers
// [RULE16] Outside holds reset low twenty clocks
// [RULE17] Sequence starts on release after minimum low
// [RULE18] Manual reset lets running bus cycle finish
// [RULE19] Outside holds manual reset past longest cycle
// [RULE20] Bus controller keeps running in manual reset
// [RULE21] Status word pushed first, then return PC
// [RULE22] NMI sets mask to 0xF, not 16
// [RULE23] Maskable accepted only above mask; NMI always
// [RULE24] Every table fetch is one aligned longword
`timescale 1ns/1ps
module exrv_exc_seq
    import exrv_pkg::*;
(
    input wire logic clk, // Core clock, 40 MHz
    input wire logic nrst, // Asynchronous system reset, active low
    input wire logic power_on_reset_n, // Power-on reset pin, active low
    input wire logic manual_reset_n, // Manual reset pin, active low
    input wire logic insn_boundary, // Previous instruction finished
    input wire logic [31:0] next_insn_pc, // Address of next instruction to run
    input wire logic ae_cpu, // CPU address error
    input wire logic ae_xfer, // Transfer-unit address error
    input wire logic nmi, // Non-maskable interrupt
    input wire logic ubrk, // User break request
    input wire logic irq_req, // Maskable interrupt request
    input wire logic [3:0] irq_level, // Its priority level
    input wire logic [7:0] irq_vec, // Its vector number
    input wire logic trap_req, // Trap instruction
    input wire logic [4:0] trap_num, // Trap number
    input wire logic ill_gen, // General illegal instruction
    input wire logic ill_slot, // Slot illegal instruction
    input wire logic sw_wr, // Core writes status word
    input wire logic [31:0] sw_wdata, // New status word
    input wire logic sp_wr, // Core writes stack register
    input wire logic [31:0] sp_wdata, // New stack register value
    input wire logic vb_wr, // Core writes vector base
    input wire logic [31:0] vb_wdata, // New vector base
    input wire logic mem_ack, // Memory completes current access
    input wire logic [31:0] mem_rdata, // Read data, valid with mem_ack
    output exrv_mem_t mem, // Memory request, held until mem_ack or power-on reset
    output logic [31:0] pc, // Start address for the core
    output logic pc_load, // Pulse: core begins at pc
    output logic [31:0] stack_gpr, // Stack pointer register
    output logic [31:0] status_word, // Status word
    output logic [31:0] vector_base, // Vector base register
    output logic core_run, // Core may execute instructions
    output logic exc_ack, // Pulse: exception accepted
    output logic periph_reset_n // Peripherals and bus controller reset
);
    typedef enum logic [2:0] {
        ST_HOLD, ST_FETCH_PC, ST_FETCH_SP, ST_RUN, ST_PUSH_SR, ST_PUSH_PC, ST_FETCH_VEC
    } exrv_state_t;

    logic rst_meta;
    logic rst_n;
    exrv_state_t state;
    logic kind_mr;
    logic [4:0] low_cnt;
    exrv_exc_t sel;
    exrv_exc_t exc;
    logic [31:0] ret_pc;
    logic [31:0] vaddr;
    logic [7:0] cur_vec;
    logic ack_now;
    logic bus_free;
    logic mr_hit;
    logic take_exc;
    logic is_reset_fetch;

    function automatic logic [4:0] sat_inc(input logic [4:0] c);
        return (c >= RESET_MIN_TCYC) ? c : c + 5'd1;
    endfunction : sat_inc

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    exrv_exc_select u_select (
        .ae_cpu(ae_cpu),
        .ae_xfer(ae_xfer),
        .nmi(nmi),
        .ubrk(ubrk),
        .irq_req(irq_req),
        .irq_level(irq_level),
        .irq_vec(irq_vec),
        .trap_req(trap_req),
        .trap_num(trap_num),
        .ill_gen(ill_gen),
        .ill_slot(ill_slot),
        .mask(status_word[MASK_MSB:MASK_LSB]),
        .sel(sel)
    );

    always_comb begin
        is_reset_fetch = (state == ST_FETCH_PC) || (state == ST_FETCH_SP);
        if (state == ST_FETCH_PC) begin
            cur_vec = kind_mr ? VEC_MR_PC : VEC_POR_PC; // [RULE1] [RULE2]
        end else if (state == ST_FETCH_SP) begin
            cur_vec = kind_mr ? VEC_MR_SP : VEC_POR_SP; // [RULE1] [RULE2]
        end else begin
            cur_vec = exc.vec;
        end
    end

    exrv_vec_addr u_vec_addr (
        .is_reset(is_reset_fetch),
        .vector_base(vector_base),
        .vec(cur_vec),
        .addr(vaddr)
    );

    assign ack_now = mem.req && mem_ack;
    // A manual reset waits for any access in flight to complete
    assign bus_free = !mem.req || mem_ack; // [RULE18]
    assign mr_hit = !manual_reset_n && bus_free;
    // Resets are checked first, so an exception never starts beside one
    assign take_exc = (state == ST_RUN) && insn_boundary && sel.valid && power_on_reset_n && !mr_hit; // [RULE13]

    // Sequencer state and reset qualification
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_HOLD;
            kind_mr <= 1'b0;
            low_cnt <= 5'h00;
            core_run <= 1'b0;
        end else if (!power_on_reset_n) begin
            state <= ST_HOLD; // [RULE13] [RULE14]
            kind_mr <= 1'b0;
            low_cnt <= sat_inc(kind_mr ? 5'h00 : low_cnt); // [RULE16]
            core_run <= 1'b0;
        end else if (mr_hit) begin
            state <= ST_HOLD; // [RULE15]
            core_run <= 1'b0;
            kind_mr <= 1'b1;
            low_cnt <= sat_inc((state == ST_HOLD && kind_mr) ? low_cnt : 5'h00);
        end else begin
            unique case (state)
                ST_HOLD: begin
                    // Pin released: a pulse shorter than the minimum is discarded
                    if (low_cnt >= RESET_MIN_TCYC) begin
                        state <= ST_FETCH_PC; // [RULE17]
                    end
                    low_cnt <= 5'h00;
                end
                ST_FETCH_PC: begin
                    if (ack_now) begin
                        state <= ST_FETCH_SP;
                    end
                end
                ST_FETCH_SP: begin
                    if (ack_now) begin
                        state <= ST_RUN; // [RULE4]
                        core_run <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (take_exc) begin
                        state <= ST_PUSH_SR; // [RULE5]
                        core_run <= 1'b0;
                    end
                end
                ST_PUSH_SR: begin
                    if (ack_now) begin
                        state <= ST_PUSH_PC; // [RULE21]
                    end
                end
                ST_PUSH_PC: begin
                    if (ack_now) begin
                        state <= ST_FETCH_VEC;
                    end
                end
                ST_FETCH_VEC: begin
                    if (ack_now) begin
                        state <= ST_RUN; // [RULE8]
                        core_run <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Accepted exception and its return address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exc <= '0;
            ret_pc <= PC_RESET;
            exc_ack <= 1'b0;
        end else begin
            exc_ack <= take_exc;
            if (take_exc) begin
                exc <= sel;
                ret_pc <= next_insn_pc; // [RULE21]
            end
        end
    end

    // Memory port: one longword per access, never dropped before mem_ack except by power-on reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem <= '0;
        end else if (!power_on_reset_n) begin
            mem <= '0;
        end else if (mem.req) begin
            if (mem_ack) begin
                mem.req <= 1'b0; // [RULE18]
            end
        end else if (manual_reset_n) begin
            unique case (state)
                ST_FETCH_PC, ST_FETCH_SP, ST_FETCH_VEC: begin
                    mem <= '{1'b1, 1'b0, vaddr, 32'h00000000}; // [RULE24] [RULE1] [RULE2] [RULE8]
                end
                ST_PUSH_SR: begin
                    mem <= '{1'b1, 1'b1, stack_gpr - STACK_WORD, status_word}; // [RULE5] [RULE21]
                end
                ST_PUSH_PC: begin
                    mem <= '{1'b1, 1'b1, stack_gpr - STACK_WORD, ret_pc}; // [RULE5] [RULE21]
                end
                ST_HOLD, ST_RUN: begin
                    mem <= mem;
                end
            endcase
        end
    end

    // Architectural registers owned by the sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RESET;
            pc_load <= 1'b0;
            stack_gpr <= 32'h00000000;
            status_word <= SW_RESET;
            vector_base <= VB_RESET;
        end else begin
            pc_load <= 1'b0;
            unique case (state)
                ST_HOLD: begin
                    vector_base <= VB_RESET; // [RULE3]
                    status_word[MASK_MSB:MASK_LSB] <= MASK_RESET; // [RULE3]
                end
                ST_FETCH_PC: begin
                    if (ack_now) begin
                        pc <= mem_rdata; // [RULE4]
                    end
                end
                ST_FETCH_SP: begin
                    if (ack_now) begin
                        stack_gpr <= mem_rdata; // [RULE4]
                        pc_load <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (sw_wr) begin
                        status_word <= sw_wdata;
                    end
                    if (sp_wr) begin
                        stack_gpr <= sp_wdata;
                    end
                    if (vb_wr) begin
                        vector_base <= vb_wdata;
                    end
                end
                ST_PUSH_SR: begin
                    if (ack_now) begin
                        stack_gpr <= stack_gpr - STACK_WORD; // [RULE5]
                    end
                end
                ST_PUSH_PC: begin
                    if (ack_now) begin
                        stack_gpr <= stack_gpr - STACK_WORD;
                        // Old mask is already on the stack, so the update is safe now
                        if (exc.is_irq) begin // [RULE7]
                            status_word[MASK_MSB:MASK_LSB] <= exc.new_mask; // [RULE6] [RULE22]
                        end
                    end
                end
                ST_FETCH_VEC: begin
                    if (ack_now) begin
                        pc <= mem_rdata; // [RULE8]
                        pc_load <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Peripherals and bus controller follow only the power-on pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_reset_n <= 1'b0;
        end else begin
            periph_reset_n <= power_on_reset_n; // [RULE14] [RULE15] [RULE20]
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sp_ack;
        state == ST_FETCH_SP && ack_now && power_on_reset_n && manual_reset_n;
    endsequence

    sequence s_vec_ack;
        state == ST_FETCH_VEC && ack_now && power_on_reset_n && manual_reset_n;
    endsequence

    sequence s_entry;
        take_exc ##1 state == ST_PUSH_SR;
    endsequence

    por_vector_addr_a: assert property ($rose(mem.req) && is_reset_fetch && !kind_mr |-> // [RULE1]
        mem.addr == (state == ST_FETCH_PC ? 32'h00000000 : 32'h00000004))
        else $error("power-on reset vector address wrong");
    mr_vector_addr_a: assert property ($rose(mem.req) && is_reset_fetch && kind_mr |-> // [RULE2]
        mem.addr == (state == ST_FETCH_PC ? 32'h00000008 : 32'h0000000c))
        else $error("manual reset vector address wrong");
    reset_init_a: assert property ($rose(state == ST_FETCH_PC) |-> // [RULE3]
        vector_base == 32'h00000000 && status_word[MASK_MSB:MASK_LSB] == 4'hf)
        else $error("reset did not clear base or set mask");
    reset_start_a: assert property (s_sp_ack |=> core_run && pc_load && stack_gpr == $past(mem_rdata)) // [RULE4]
        else $error("start after reset fetch wrong");
    stack_order_a: assert property (s_entry ##1 $rose(mem.req) |-> // [RULE21]
        mem.we && mem.wdata == status_word && mem.addr == stack_gpr - 32'h00000004)
        else $error("status word not stacked first");
    irq_mask_a: assert property (state == ST_PUSH_PC && ack_now && exc.is_irq && power_on_reset_n |=> // [RULE6]
        status_word[MASK_MSB:MASK_LSB] == $past(exc.new_mask))
        else $error("interrupt mask not updated");
    keep_mask_a: assert property (state == ST_PUSH_PC && !exc.is_irq && !sw_wr |=> // [RULE7]
        $stable(status_word))
        else $error("mask changed on non-interrupt entry");
    vec_fetch_addr_a: assert property ($rose(mem.req) && state == ST_FETCH_VEC |-> // [RULE10]
        mem.addr == {vector_base[31:2] + exc.vec, 2'h0} && !mem.we)
        else $error("handler vector address wrong");
    handler_jump_a: assert property (s_vec_ack |=> pc == $past(mem_rdata) && pc_load && core_run) // [RULE8]
        else $error("handler start not loaded");
    por_priority_a: assert property (!power_on_reset_n |=> state == ST_HOLD && !kind_mr && !mem.req) // [RULE13]
        else $error("power-on reset not dominant");
    short_pulse_a: assert property (state == ST_HOLD && low_cnt < RESET_MIN_TCYC |=> state != ST_FETCH_PC) // [RULE17]
        else $error("reset released too early");
    bus_finish_a: assert property (mem.req && !mem_ack && power_on_reset_n |=> mem.req && $stable(mem.addr)) // [RULE18]
        else $error("access dropped before completion");
    periph_manual_reset_n_a: assert property (power_on_reset_n && !manual_reset_n |=> periph_reset_n) // [RULE15]
        else $error("manual reset reached peripherals");
    aligned_fetch_a: assert property (mem.req |-> mem.addr[1:0] == 2'h0) // [RULE24]
        else $error("unaligned access");

endmodule : exrv_exc_seq

// file: exrv_mem_model.sv
// Memory partner answering reads with address-derived data and ignoring write data, with a chosen latency
`timescale 1ns/1ps
module exrv_mem_model
    import exrv_pkg::*;
(
    input wire logic clk, // Core clock
    input exrv_mem_t mem, // Request from the sequencer
    input wire logic [3:0] lat, // Extra wait cycles before each answer
    output logic mem_ack, // One-cycle completion pulse
    output logic [31:0] mem_rdata // Read data, meaningful only with mem_ack
);
    logic [3:0] cnt;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
        cnt = 4'h0;
    end
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        // Outside the answer cycle the data lines keep flipping so stale data never matches
        mem_rdata <= ~mem_rdata;
        if (!mem.req) begin
            cnt <= 4'h0;
        end else if (!mem_ack) begin
            if (cnt >= lat) begin
                mem_ack <= 1'b1;
                mem_rdata <= {mem.addr[29:0], 2'b00} ^ 32'hc0de0000;
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : exrv_mem_model

// file: exrv_pkg.sv
// Shared constants, types and helpers for the exception entry sequencer
package exrv_pkg;

    // Reset pins must stay low at least this many core clocks before release counts
    localparam logic [4:0] RESET_MIN_TCYC = 5'd20;

    // Vector numbers
    localparam logic [7:0] VEC_POR_PC = 8'h00;
    localparam logic [7:0] VEC_POR_SP = 8'h01;
    localparam logic [7:0] VEC_MR_PC = 8'h02;
    localparam logic [7:0] VEC_MR_SP = 8'h03;
    localparam logic [7:0] VEC_ILL_GEN = 8'h04;
    localparam logic [7:0] VEC_ILL_SLOT = 8'h06;
    localparam logic [7:0] VEC_AE_CPU = 8'h09;
    localparam logic [7:0] VEC_AE_XFER = 8'h0a;
    localparam logic [7:0] VEC_NMI = 8'h0b;
    localparam logic [7:0] VEC_UBRK = 8'h0c;
    localparam logic [7:0] VEC_TRAP_LO = 8'h20;
    localparam logic [7:0] VEC_IRQ_LO = 8'h40;

    // Status word layout and reset values
    localparam int MASK_LSB = 4;
    localparam int MASK_MSB = 7;
    localparam logic [3:0] MASK_RESET = 4'hf;
    localparam logic [3:0] MASK_NMI = 4'hf;
    localparam logic [3:0] LEVEL_UBRK = 4'hf;
    localparam logic [31:0] SW_RESET = 32'h000000f0;
    localparam logic [31:0] VB_RESET = 32'h00000000;
    localparam logic [31:0] PC_RESET = 32'h00000000;
    localparam logic [31:0] STACK_WORD = 32'h00000004;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } exrv_mem_t;

    typedef struct packed {
        logic valid;
        logic [7:0] vec;
        logic is_irq;
        logic [3:0] new_mask;
    } exrv_exc_t;

    // Table offset of a vector: four bytes per entry
    function automatic logic [31:0] exrv_vec_ofs(input logic [7:0] vec);
        return {22'h0, vec, 2'h0};
    endfunction : exrv_vec_ofs

endpackage : exrv_pkg

// file: exrv_vec_addr.sv
// Vector table address computation
`timescale 1ns/1ps
module exrv_vec_addr
    import exrv_pkg::*;
(
    input wire logic is_reset, // Reset vectors ignore the base
    input wire logic [31:0] vector_base, // Relocatable table base
    input wire logic [7:0] vec, // Vector number
    output logic [31:0] addr // Longword-aligned table address
);
    logic [31:0] sum;

    always_comb begin
        sum = is_reset ? exrv_vec_ofs(vec) : vector_base + exrv_vec_ofs(vec); // [RULE9] [RULE10]
        addr = {sum[31:2], 2'h0}; // [RULE24]
    end

endmodule : exrv_vec_addr

// file: tb_top.sv
// Self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_top;
    import exrv_pkg::*;
    logic clk, nrst, power_on_reset_n, manual_reset_n, insn_boundary, pc_load, core_run, exc_ack, periph_reset_n;
    logic ae_cpu, ae_xfer, nmi, ubrk, irq_req, trap_req, ill_slot, ill_gen, sw_wr, sp_wr, vb_wr, mem_ack;
    logic [3:0] irq_level, lat;
    logic [4:0] trap_num;
    logic [7:0] irq_vec, src;
    logic [31:0] next_insn_pc, sw_wdata, sp_wdata, vb_wdata, mem_rdata, pc, stack_gpr, status_word, vector_base;
    exrv_mem_t mem;
    logic [64:0] q[$];
    int errors = 0;
    int check_count = 0;
    assign {ae_cpu, ae_xfer, nmi, ubrk, irq_req, trap_req, ill_slot, ill_gen} = src;
    exrv_exc_seq exrv_exc_seq_i (.clk, .nrst, .power_on_reset_n, .manual_reset_n, .insn_boundary, .next_insn_pc,
        .ae_cpu, .ae_xfer, .nmi, .ubrk, .irq_req, .irq_level, .irq_vec, .trap_req, .trap_num, .ill_gen, .ill_slot,
        .sw_wr, .sw_wdata, .sp_wr, .sp_wdata, .vb_wr, .vb_wdata, .mem_ack, .mem_rdata, .mem, .pc, .pc_load,
        .stack_gpr, .status_word, .vector_base, .core_run, .exc_ack, .periph_reset_n);
    exrv_mem_model exrv_mem_model_i (.clk, .mem, .lat, .mem_ack, .mem_rdata);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem.req && mem_ack) q.push_back({mem.we, mem.addr, mem.wdata});
    end
    function automatic logic [31:0] tbl(input logic [31:0] a);
        return {a[29:0], 2'b00} ^ 32'hc0de0000;
    endfunction : tbl
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic chk_acc(input logic we, input logic [31:0] a, input logic [31:0] d);
        logic [64:0] e;
        `CHK("access present", 1'b1, q.size() > 0)
        e = (q.size() > 0) ? q.pop_front() : 65'h0;
        `CHK("mem.we", we, e[64])
        `CHK("mem.addr", a, e[63:32])
        if (we) `CHK("mem.wdata", d, e[31:0])
    endtask : chk_acc
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pc_load !== 1'b1 && n < 300);
        `CHK("pc_load", 1'b1, pc_load)
    endtask : wait_load
    // Pins are held low for len clocks; too short a pulse must not restart the core
    task automatic do_reset(input logic por, input int len);
        logic [31:0] b;
        b = por ? 32'h0 : 32'h8;
        @(posedge clk);
        if (por) power_on_reset_n <= 1'b0;
        else manual_reset_n <= 1'b0;
        repeat (len) @(posedge clk);
        `CHK("periph_reset_n", !por, periph_reset_n)
        power_on_reset_n <= 1'b1;
        manual_reset_n <= 1'b1;
        if (len < 20) begin
            repeat (20) @(posedge clk);
            `CHK("core_run", 1'b0, core_run)
            `CHK("accesses", 0, q.size())
        end else begin
            wait_load();
            chk_acc(1'b0, b, 32'h0);
            chk_acc(1'b0, b + 32'h4, 32'h0);
            `CHK("pc", tbl(b), pc)
            `CHK("stack_gpr", tbl(b + 32'h4), stack_gpr)
            `CHK("mask", MASK_RESET, status_word[MASK_MSB:MASK_LSB])
            `CHK("vector_base", 32'h0, vector_base)
            `CHK("core_run", 1'b1, core_run)
        end
    endtask : do_reset
    task automatic do_exc(input logic [7:0] s, input logic [7:0] vec, input logic irq, input logic [3:0] lvl);
        logic [3:0] m;
        logic [31:0] sp, vb, np, sw, va;
        int n;
        m = irq ? 4'($urandom_range(lvl - 1)) : 4'($urandom_range(14));
        sp = ($urandom & 32'h00fffffc) | 32'h100;
        vb = $urandom & 32'h0ffffc00;
        np = $urandom & 32'hfffffffe;
        sw = {24'h0, m, 4'h0};
        va = vb + {22'h0, vec, 2'b00};
        @(posedge clk);
        {sw_wr, sp_wr, vb_wr} <= 3'b111;
        sw_wdata <= sw;
        sp_wdata <= sp;
        vb_wdata <= vb;
        lat <= 4'($urandom_range(3));
        irq_level <= lvl;
        irq_vec <= vec;
        trap_num <= vec[4:0];
        @(posedge clk);
        {sw_wr, sp_wr, vb_wr} <= 3'b000;
        src <= s;
        next_insn_pc <= np;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (exc_ack !== 1'b1 && n < 20);
        `CHK("exc_ack", 1'b1, exc_ack)
        @(posedge clk);
        src <= 8'h0;
        wait_load();
        chk_acc(1'b1, sp - 32'h4, sw);
        chk_acc(1'b1, sp - 32'h8, np);
        chk_acc(1'b0, va, 32'h0);
        `CHK("pc", tbl(va), pc)
        `CHK("stack_gpr", sp - 32'h8, stack_gpr)
        `CHK("mask", irq ? lvl : m, status_word[MASK_MSB:MASK_LSB])
    endtask : do_exc
    initial begin
        nrst = 1'b0;
        {power_on_reset_n, manual_reset_n, insn_boundary} = 3'b110;
        {src, irq_level, irq_vec, trap_num, lat} = '0;
        {next_insn_pc, sw_wdata, sp_wdata, vb_wdata} = '0;
        {sw_wr, sp_wr, vb_wr} = 3'b000;
        void'($urandom(57206));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        insn_boundary <= 1'b1;
        repeat (3) @(posedge clk);
        do_reset(1'b1, 20);
        do_reset(1'b1, 10);
        lat <= 4'h3;
        do_reset(1'b1, 25);
        do_exc(8'h80, VEC_AE_CPU, 1'b0, 4'h0);
        do_exc(8'h41, VEC_AE_XFER, 1'b0, 4'h0);
        do_exc(8'h28, VEC_NMI, 1'b1, MASK_NMI);
        do_exc(8'h10, VEC_UBRK, 1'b1, LEVEL_UBRK);
        do_exc(8'h08, VEC_IRQ_LO + 8'($urandom_range(191)), 1'b1, 4'($urandom_range(15, 1)));
        do_exc(8'h04, VEC_TRAP_LO + 8'($urandom_range(31)), 1'b0, 4'h0);
        do_exc(8'h02, VEC_ILL_SLOT, 1'b0, 4'h0);
        do_exc(8'h01, VEC_ILL_GEN, 1'b0, 4'h0);
        // A maskable request at the mask level itself is never taken
        @(posedge clk);
        {sw_wr, sp_wr} <= 2'b11;
        sw_wdata <= 32'h00000090;
        sp_wdata <= 32'h00001000;
        irq_level <= 4'h9;
        @(posedge clk);
        {sw_wr, sp_wr} <= 2'b00;
        src <= 8'h08;
        repeat (12) begin
            @(posedge clk);
            `CHK("exc_ack refused", 1'b0, exc_ack)
        end
        // Manual reset lands in a slow stack write: that write ends, the second push never starts
        src <= 8'h01;
        lat <= 4'h7;
        repeat (3) @(posedge clk);
        manual_reset_n <= 1'b0;
        src <= 8'h00;
        repeat (12) @(posedge clk);
        chk_acc(1'b1, 32'h00000ffc, 32'h00000090);
        `CHK("accesses", 0, q.size())
        do_reset(1'b0, 24);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule : tb_top
